// [include/cpu_core_params.svh]
// cpu_core_params.svh: offsets, widths, reset values and timing counts
// assumes inclusion by the package, the checker and the testbench
`ifndef CPU_CORE_PARAMS_SVH
`define CPU_CORE_PARAMS_SVH

// =====================================================================
// clock
`define CLK_SYS_PERIOD_NS 4
`define ICLK_DIV 3
`define CLKMODE_DEFAULT 2'h3

// =====================================================================
// apb register byte offsets
`define REG_CTRL 12'h000
`define REG_OP 12'h004
`define REG_ACC 12'h008
`define REG_BREG 12'h00c
`define REG_EREG 12'h010
`define REG_DREG 12'h014
`define REG_PC 12'h018
`define REG_STATUS 12'h01c
`define REG_MEM 12'h020
`define REG_DPTR 12'h024
`define REG_VECTOR 12'h028

// =====================================================================
// op field in REG_OP: bits 4:0 code, bits 11:8 immediate / bit index
`define OP_CODE_LSB 0
`define OP_IMM_LSB 8
`define OP_TGT_LSB 16

// =====================================================================
// widths
`define PC_W 12
`define PAGE_LSB 7
`define DP_W 10
`define STACK_DEPTH 8
`endif

// [include/cpu_core_pkg.sv]
// cpu_core_pkg: types for the register and stack core
// assumes cpu_core_params.svh sits on the include path
package cpu_core_pkg;
`include "cpu_core_params.svh"

    typedef enum logic [4:0] {
        OP_NOP, OP_ADD_IMM, add_memory_op, add_memory_carry_op,
        OP_AND_MEM, OP_OR_MEM, OP_CMP_MEM, OP_SET_BIT, OP_CLR_BIT,
        rotate_right_op, set_carry_op, clear_carry_op,
        OP_B_TO_E, OP_E_TO_B, OP_XCH_E, OP_LOAD_D,
        OP_CALL, OP_RETURN, table_lookup_op, page_branch_op,
        special_page_call_op, read_stack_level_op, OP_INT_ENTRY,
        OP_INT_RETURN, OP_SET_SKIP, OP_BACKUP_RETURN
    } op_code_t;

    typedef struct packed {
        logic [`DP_W-1:0] dptr;
        logic carry;
        logic skip;
        logic [3:0] acc;
        logic [3:0] breg;
    } context_t;

    typedef enum {ST_IDLE, ST_EXEC} seq_state_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } apb_resp_t;
endpackage : cpu_core_pkg

// [hdl/cpu_register_stack_core.sv]
// cpu_register_stack_core: accumulator, carry, B/E/D registers, return
// stack, interrupt context save and the clock dividers of a 4-bit cpu.
// assumes an apb master on CLK_SYS; software plays the fetch/decode side
// by writing operations into REG_OP and memory data into REG_MEM.
`timescale 1ns/1ps

// Functional notes
// - mode bits 3:2 select system clock divide by 1, 2, 4 or 8.
// - divide-by-8 mode is selected at reset and backup return.
// - instruction clock is system clock over three; one machine cycle.
// - alu does 4-bit add, compare, and, or and bit manipulation.
// - add memory with carry sets carry on carry out.
// - add immediate and plain add memory leave carry unchanged.
// - rotate right moves accumulator bit 0 into carry.
// - set carry forces one, clear carry forces zero.
// - B is a 4-bit register pairing with accumulator for 8 bits.
// - 8-bit E exchanges with B (high) and accumulator (low).
// - 3-bit D with accumulator forms 7-bit in-page rom pointer.
// - pc is pushed on interrupt entry, call and table lookup.
// - return stack has eight identical entries, eight nesting levels.
// - stack wraps unprotected; push at pointer 7 goes to 0.
// - 3-bit stack pointer is copied to accumulator by read level.
// - interrupt entry saves dptr, carry, skip, A and B.
// - only interrupt entry writes the context save register.
// - skip flag suppresses next instruction; kept across interrupts.
// - pc is page field plus 7-bit in-page field; in-page overflow carries into the page.
// - interrupt entry loads vector while pushing return address.
module cpu_register_stack_core
    import cpu_core_pkg::*;
#(
    parameter int PC_WIDTH = `PC_W
) (
    // clock and reset
    input wire logic CLK_SYS,
    input wire logic RST_N,
    // apb slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // clocks out
    output logic SYS_CLK_EN,
    output logic INSTR_CLK_EN
);

    // =================================================================
    // state
    typedef struct packed {
        logic [1:0] clock_mode_reg;
        logic [2:0] div_cnt;
        logic [1:0] iclk_cnt;
        logic sys_en;
        logic iclk_en;
        logic [3:0] acc;
        logic carry_bit;
        logic [3:0] breg;
        logic [7:0] ereg;
        logic [2:0] dreg;
        logic skip;
        logic [PC_WIDTH-1:0] pc;
        logic [2:0] stack_level_ptr;
        logic [7:0][PC_WIDTH-1:0] return_stack;
        context_t interrupt_context_save;
        logic [3:0] mem;
        logic [`DP_W-1:0] dptr;
        logic [PC_WIDTH-1:0] vector;
        logic op_pend;
        logic [31:0] op_word;
        logic busy;
        apb_resp_t resp;
    } core_t;

    core_t s_q, s_d;

    function automatic logic [2:0] div_mask(input logic [1:0] mode);
        case (mode)
            2'h0: div_mask = 3'h0;
            2'h1: div_mask = 3'h1;
            2'h2: div_mask = 3'h3;
            default: div_mask = 3'h7;
        endcase
    endfunction : div_mask

    function automatic logic [PC_WIDTH-1:0] in_page(
        input logic [PC_WIDTH-1:0] pc, input logic [2:0] d,
        input logic [3:0] a);
        in_page = {pc[PC_WIDTH-1:`PAGE_LSB], d, a};
    endfunction : in_page

    logic [4:0] sum;
    logic [3:0] imm;
    logic [PC_WIDTH-1:0] tgt;
    logic [2:0] sp_up;
    logic [2:0] sp_dn;
    logic access;
    op_code_t op;

    always_comb begin
        s_d = s_q;
        op = op_code_t'(s_q.op_word[`OP_CODE_LSB +: 5]);
        imm = s_q.op_word[`OP_IMM_LSB +: 4];
        tgt = s_q.op_word[`OP_TGT_LSB +: PC_WIDTH];
        sp_up = s_q.stack_level_ptr + 3'h1;
        sp_dn = s_q.stack_level_ptr - 3'h1;
        sum = 5'h0;
        access = PSEL && PENABLE;

        // =============================================================
        // clock dividers
        // a mode change restarts the count at the next wrap, so the first
        // tick after it may come early; nothing else sees the change
        s_d.div_cnt = (s_q.div_cnt >= div_mask(s_q.clock_mode_reg)) ?
            3'h0 : s_q.div_cnt + 3'h1;
        s_d.sys_en = (s_d.div_cnt == 3'h0);
        s_d.iclk_en = 1'b0;
        if (s_q.sys_en) begin
            s_d.iclk_cnt = (s_q.iclk_cnt == 2'(`ICLK_DIV - 1)) ?
                2'h0 : s_q.iclk_cnt + 2'h1;
            s_d.iclk_en = (s_q.iclk_cnt == 2'(`ICLK_DIV - 1));
        end

        // =============================================================
        // operation executes on one machine cycle boundary
        if (s_q.op_pend && s_q.iclk_en) begin
            s_d.op_pend = 1'b0;
            s_d.busy = 1'b0;
            if (s_q.skip && op != OP_INT_ENTRY &&
                    op != OP_INT_RETURN) begin
                s_d.skip = 1'b0;
            end else begin
                s_d.pc[`PAGE_LSB-1:0] = s_q.pc[`PAGE_LSB-1:0] + 7'h1;
                if (s_q.pc[`PAGE_LSB-1:0] == 7'h7f)
                    s_d.pc = s_q.pc + 1'b1;
                case (op)
                    OP_ADD_IMM: begin
                        s_d.acc = s_q.acc + imm;
                    end
                    add_memory_op: begin
                        s_d.acc = s_q.acc + s_q.mem;
                    end
                    add_memory_carry_op: begin
                        sum = {1'b0, s_q.acc} + {1'b0, s_q.mem} +
                            {4'h0, s_q.carry_bit};
                        s_d.acc = sum[3:0];
                        s_d.carry_bit = sum[4];
                    end
                    OP_AND_MEM: s_d.acc = s_q.acc & s_q.mem;
                    OP_OR_MEM: s_d.acc = s_q.acc | s_q.mem;
                    OP_CMP_MEM: s_d.skip = (s_q.acc == s_q.mem);
                    OP_SET_BIT: s_d.mem[imm[1:0]] = 1'b1;
                    OP_CLR_BIT: s_d.mem[imm[1:0]] = 1'b0;
                    rotate_right_op: begin
                        s_d.acc = {s_q.carry_bit, s_q.acc[3:1]};
                        s_d.carry_bit = s_q.acc[0];
                    end
                    set_carry_op: s_d.carry_bit = 1'b1;
                    clear_carry_op: s_d.carry_bit = 1'b0;
                    OP_B_TO_E: s_d.ereg = {s_q.breg, s_q.acc};
                    OP_E_TO_B: begin
                        s_d.breg = s_q.ereg[7:4];
                        s_d.acc = s_q.ereg[3:0];
                    end
                    OP_XCH_E: begin
                        s_d.ereg = {s_q.breg, s_q.acc};
                        s_d.breg = s_q.ereg[7:4];
                        s_d.acc = s_q.ereg[3:0];
                    end
                    OP_LOAD_D: s_d.dreg = imm[2:0];
                    OP_CALL: begin
                        // no overflow guard: a ninth push overwrites
                        s_d.return_stack[sp_up] = s_d.pc;
                        s_d.stack_level_ptr = sp_up;
                        s_d.pc = tgt;
                    end
                    OP_RETURN: begin
                        s_d.pc = s_q.return_stack[s_q.stack_level_ptr];
                        s_d.stack_level_ptr = sp_dn;
                    end
                    table_lookup_op: begin
                        // pc parks on the table word; fetch side returns
                        s_d.return_stack[sp_up] = s_d.pc;
                        s_d.stack_level_ptr = sp_up;
                        s_d.pc = {tgt[PC_WIDTH-1:`PAGE_LSB], s_q.dreg,
                            s_q.acc};
                    end
                    page_branch_op: begin
                        s_d.pc = in_page(tgt, s_q.dreg, s_q.acc);
                    end
                    special_page_call_op: begin
                        s_d.return_stack[sp_up] = s_d.pc;
                        s_d.stack_level_ptr = sp_up;
                        s_d.pc = in_page(tgt, s_q.dreg, s_q.acc);
                    end
                    read_stack_level_op: begin
                        s_d.acc = {1'b0, s_q.stack_level_ptr};
                    end
                    OP_INT_ENTRY: begin
                        // interrupted instruction not consumed: push pc
                        s_d.pc = s_q.vector;
                        s_d.return_stack[sp_up] = s_q.pc;
                        s_d.stack_level_ptr = sp_up;
                        // only writer of the context save
                        s_d.interrupt_context_save = '{dptr: s_q.dptr,
                            carry: s_q.carry_bit, skip: s_q.skip,
                            acc: s_q.acc, breg: s_q.breg};
                        s_d.skip = 1'b0;
                    end
                    OP_INT_RETURN: begin
                        s_d.pc = s_q.return_stack[s_q.stack_level_ptr];
                        s_d.stack_level_ptr = sp_dn;
                        s_d.dptr = s_q.interrupt_context_save.dptr;
                        s_d.carry_bit = s_q.interrupt_context_save.carry;
                        s_d.skip = s_q.interrupt_context_save.skip;
                        s_d.acc = s_q.interrupt_context_save.acc;
                        s_d.breg = s_q.interrupt_context_save.breg;
                    end
                    OP_SET_SKIP: s_d.skip = 1'b1;
                    OP_BACKUP_RETURN: begin
                        s_d.clock_mode_reg = `CLKMODE_DEFAULT;
                    end
                    default: begin
                    end
                endcase
            end
        end

        // =============================================================
        // apb slave: one wait state except REG_OP writes while an op pends
        // a write lands one edge before the master samples ready; the
        // master still holds the request, so no reader sees it early
        s_d.resp.pready = 1'b0;
        s_d.resp.pslverr = 1'b0;
        if (PSEL && !PENABLE) begin
            s_d.resp.prdata = 32'h0;
            case (PADDR)
                `REG_CTRL: s_d.resp.prdata[3:2] = s_q.clock_mode_reg;
                `REG_OP: s_d.resp.prdata = s_q.op_word;
                `REG_ACC: s_d.resp.prdata[3:0] = s_q.acc;
                `REG_BREG: s_d.resp.prdata[3:0] = s_q.breg;
                `REG_EREG: s_d.resp.prdata[7:0] = s_q.ereg;
                `REG_DREG: s_d.resp.prdata[2:0] = s_q.dreg;
                `REG_PC: s_d.resp.prdata[PC_WIDTH-1:0] = s_q.pc;
                `REG_STATUS: s_d.resp.prdata[5:0] = {s_q.busy,
                    s_q.skip, s_q.carry_bit, s_q.stack_level_ptr};
                `REG_MEM: s_d.resp.prdata[3:0] = s_q.mem;
                `REG_DPTR: s_d.resp.prdata[`DP_W-1:0] = s_q.dptr;
                `REG_VECTOR: s_d.resp.prdata[PC_WIDTH-1:0] = s_q.vector;
                default: s_d.resp.pslverr = 1'b1;
            endcase
            // hold error until the access phase
            s_d.resp.pslverr = 1'b0;
        end
        if (access && !s_q.resp.pready) begin
            s_d.resp.pready = !(PWRITE && PADDR == `REG_OP && s_q.op_pend);
            s_d.resp.pslverr = s_d.resp.pready && !(PADDR <= `REG_VECTOR);
            if (PWRITE && s_d.resp.pready) begin
                case (PADDR)
                    `REG_CTRL: s_d.clock_mode_reg = PWDATA[3:2];
                    `REG_OP: begin
                        s_d.op_word = PWDATA;
                        s_d.op_pend = 1'b1;
                        s_d.busy = 1'b1;
                    end
                    `REG_ACC: s_d.acc = PWDATA[3:0];
                    `REG_BREG: s_d.breg = PWDATA[3:0];
                    `REG_EREG: s_d.ereg = PWDATA[7:0];
                    `REG_DREG: s_d.dreg = PWDATA[2:0];
                    `REG_PC: s_d.pc = PWDATA[PC_WIDTH-1:0];
                    `REG_MEM: s_d.mem = PWDATA[3:0];
                    `REG_DPTR: s_d.dptr = PWDATA[`DP_W-1:0];
                    `REG_VECTOR: s_d.vector = PWDATA[PC_WIDTH-1:0];
                    default: begin
                    end
                endcase
            end
        end
    end

    // =================================================================
    // registers; E and D clear to zero here though software must not rely
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            s_q <= '0;
            s_q.clock_mode_reg <= `CLKMODE_DEFAULT;
        end else begin
            s_q <= s_d;
        end
    end

    assign PRDATA = s_q.resp.prdata;
    assign PREADY = s_q.resp.pready;
    assign PSLVERR = s_q.resp.pslverr;
    assign SYS_CLK_EN = s_q.sys_en;
    assign INSTR_CLK_EN = s_q.iclk_en;

endmodule : cpu_register_stack_core

// [verification/cpu_core_checker.sv]
// cpu_core_checker: port-level assertions for cpu_register_stack_core
// assumes the parameter header on the include path; bound at the foot
`timescale 1ns/1ps
`include "cpu_core_params.svh"
module cpu_core_checker
    import cpu_core_pkg::*;
(
    // clock and reset
    input wire logic CLK_SYS,
    input wire logic RST_N,
    // apb
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [31:0] PRDATA,
    input wire logic PREADY,
    input wire logic PSLVERR,
    // clock enables
    input wire logic SYS_CLK_EN,
    input wire logic INSTR_CLK_EN
);
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!RST_N);
    // =========================================================
    // mode tracking; hold_q masks the gaps around a mode change
    logic [3:0] gap_q;
    logic [1:0] mode_q;
    logic [1:0] sc_q;
    logic [2:0] hold_q;
    logic seen_q;
    logic wr_ok;
    assign wr_ok = PSEL && PENABLE && PREADY && PWRITE;
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            gap_q <= 4'h0;
            mode_q <= 2'h3;
            sc_q <= 2'h0;
            hold_q <= 3'h2;
            seen_q <= 1'b0;
        end else begin
            gap_q <= SYS_CLK_EN ? 4'h1 : gap_q + 4'(gap_q != 4'hf);
            if (wr_ok && PADDR == `REG_CTRL) begin
                mode_q <= PWDATA[3:2];
                hold_q <= 3'h5;
            end else if (wr_ok && PADDR == `REG_OP &&
                         PWDATA[4:0] == OP_BACKUP_RETURN) begin
                mode_q <= 2'h3;
                hold_q <= 3'h5;
            end else if (SYS_CLK_EN && hold_q != 3'h0) begin
                hold_q <= hold_q - 3'h1;
            end
            if (INSTR_CLK_EN) begin
                sc_q <= 2'h0;
                seen_q <= 1'b1;
            end else if (SYS_CLK_EN) begin
                sc_q <= sc_q + 2'h1;
            end
        end
    end
    // =========================================================
    // assertions
    AST_SYS_DIV: assert property (
        SYS_CLK_EN && hold_q == 3'h0 |-> gap_q == (4'h1 << mode_q))
        else $error("system clock gap wrong for mode");
    AST_INSTR_DIV3: assert property (
        INSTR_CLK_EN && seen_q && hold_q == 3'h0 && mode_q != 2'h0
        |-> 3'(sc_q) + 3'(SYS_CLK_EN) == 3'h3)
        else $error("instruction clock not every third tick");
    AST_READY_PULSE: assert property (PREADY |=> !PREADY)
        else $error("ready longer than one cycle");
    AST_READY_ACCESS: assert property (PREADY |-> PSEL && PENABLE)
        else $error("ready outside access phase");
    AST_ERR_READY: assert property (PSLVERR |-> PREADY)
        else $error("error without ready");
    AST_UNMAPPED: assert property (
        PREADY && PADDR > `REG_VECTOR |-> PSLVERR)
        else $error("unmapped access not refused");
    AST_MAPPED: assert property (
        PREADY && PADDR <= `REG_VECTOR && PADDR[1:0] == 2'h0 |-> !PSLVERR)
        else $error("mapped access refused");
    AST_WAIT_ONE: assert property (
        PSEL && $rose(PENABLE) && !(PWRITE && PADDR == `REG_OP)
        |-> !PREADY ##1 PREADY)
        else $error("answer not after one wait state");
    AST_ANSWER_BOUND: assert property (
        PSEL && $rose(PENABLE) |-> ##[0:200] PREADY)
        else $error("no answer");
    COV_FAST: cover property (SYS_CLK_EN && mode_q == 2'h0);
    COV_ERR: cover property (PSLVERR);
    COV_INSTR: cover property (INSTR_CLK_EN && seen_q);
endmodule : cpu_core_checker

bind cpu_register_stack_core cpu_core_checker i_chk (
    .CLK_SYS(CLK_SYS), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
    .PREADY(PREADY), .PSLVERR(PSLVERR), .SYS_CLK_EN(SYS_CLK_EN),
    .INSTR_CLK_EN(INSTR_CLK_EN));

// [verification/tb.sv]
// tb: apb-driven tests of the register and stack core
// assumes the package and the parameter header are compiled first
`timescale 1ns/1ps
`include "cpu_core_params.svh"
module tb;
    import cpu_core_pkg::*;
    logic clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0;
    logic [11:0] pa = 12'h000;
    logic [31:0] pwd = 32'h0, prd, r;
    logic prdy, perr, e, sclk, iclk;
    int num_errors = 0, checks_done = 0, cyc = 0, i;
    always #2 clk = ~clk;
    cpu_register_stack_core i_dut (.CLK_SYS(clk), .RST_N(rst_n),
        .PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(pa),
        .PWDATA(pwd), .PRDATA(prd), .PREADY(prdy), .PSLVERR(perr),
        .SYS_CLK_EN(sclk), .INSTR_CLK_EN(iclk));
    // =========================================================
    // tasks
    task results;
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : results
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        pa <= a;
        pwd <= d;
        @(posedge clk);
        pen <= 1'b1;
        do @(posedge clk); while (prdy !== 1'b1);
        r = prd;
        e = perr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask : apb
    task wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task chkrd(input logic [11:0] a, input logic [31:0] m,
               input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(r & m, exp);
    endtask : chkrd
    // op waits for busy to drop; the timeout covers a stuck core
    task op(input op_code_t c, input logic [3:0] im = 4'h0,
            input logic [11:0] t = 12'h000);
        wr(`REG_OP, {4'h0, t, 4'h0, im, 3'h0, c});
        do apb(1'b0, `REG_STATUS, 32'h0); while (r[5] !== 1'b0);
    endtask : op
    always @(posedge clk) begin
        cyc++;
        if (cyc == 30000) begin
            num_errors++;
            $display("[ERR] %0t timeout", $time);
            results();
        end
    end
    // =========================================================
    // tests
    initial begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        chkrd(`REG_CTRL, 32'hc, 32'hc);
        chkrd(`REG_STATUS, 32'h7, 32'h0);
        $display("test reset done");
        wr(`REG_ACC, 32'h9);
        wr(`REG_MEM, 32'h8);
        op(clear_carry_op);
        op(add_memory_carry_op);
        chkrd(`REG_ACC, 32'hf, 32'h1);
        chkrd(`REG_STATUS, 32'h8, 32'h8);
        op(add_memory_op);
        chkrd(`REG_ACC, 32'hf, 32'h9);
        op(OP_ADD_IMM, 4'h8);
        chkrd(`REG_STATUS, 32'hf, 32'h8);
        op(clear_carry_op);
        chkrd(`REG_STATUS, 32'h8, 32'h0);
        op(add_memory_op);
        chkrd(`REG_STATUS, 32'h8, 32'h0);
        op(set_carry_op);
        chkrd(`REG_STATUS, 32'h8, 32'h8);
        op(clear_carry_op);
        wr(`REG_ACC, 32'h5);
        op(rotate_right_op);
        chkrd(`REG_STATUS, 32'h8, 32'h8);
        op(rotate_right_op);
        chkrd(`REG_STATUS, 32'h8, 32'h0);
        wr(`REG_ACC, 32'hc);
        wr(`REG_MEM, 32'ha);
        op(OP_AND_MEM);
        chkrd(`REG_ACC, 32'hf, 32'h8);
        wr(`REG_ACC, 32'hc);
        op(OP_OR_MEM);
        chkrd(`REG_ACC, 32'hf, 32'he);
        op(OP_CMP_MEM);
        chkrd(`REG_STATUS, 32'h10, 32'h0);
        wr(`REG_MEM, 32'he);
        op(OP_CMP_MEM);
        chkrd(`REG_STATUS, 32'h10, 32'h10);
        op(OP_ADD_IMM, 4'h1);
        chkrd(`REG_ACC, 32'hf, 32'he);
        chkrd(`REG_STATUS, 32'h10, 32'h0);
        $display("test alu done");
        wr(`REG_ACC, 32'h3);
        wr(`REG_BREG, 32'ha);
        op(OP_B_TO_E);
        chkrd(`REG_EREG, 32'hff, 32'ha3);
        wr(`REG_EREG, 32'h5c);
        op(OP_E_TO_B);
        chkrd(`REG_BREG, 32'hf, 32'h5);
        chkrd(`REG_ACC, 32'hf, 32'hc);
        wr(`REG_DREG, 32'hf);
        chkrd(`REG_DREG, 32'hf, 32'h7);
        $display("test regs done");
        wr(`REG_DREG, 32'h5);
        wr(`REG_ACC, 32'ha);
        wr(`REG_PC, 32'h123);
        op(table_lookup_op, 4'h0, 12'h180);
        chkrd(`REG_PC, 32'hfff, 32'h1da);
        chkrd(`REG_STATUS, 32'h7, 32'h1);
        op(OP_RETURN);
        chkrd(`REG_STATUS, 32'h7, 32'h0);
        for (i = 0; i < 3; i++) op(OP_CALL, 4'h0, 12'h100);
        op(read_stack_level_op);
        chkrd(`REG_ACC, 32'hf, 32'h3);
        for (i = 0; i < 5; i++) op(OP_CALL, 4'h0, 12'h100);
        chkrd(`REG_STATUS, 32'h7, 32'h0);
        op(OP_RETURN);
        chkrd(`REG_STATUS, 32'h7, 32'h7);
        $display("test stack done");
        wr(`REG_VECTOR, 32'h80);
        wr(`REG_DPTR, 32'h2a5);
        wr(`REG_ACC, 32'h6);
        wr(`REG_BREG, 32'h9);
        op(set_carry_op);
        op(OP_SET_SKIP);
        op(OP_INT_ENTRY);
        chkrd(`REG_PC, 32'hfff, 32'h80);
        chkrd(`REG_STATUS, 32'h7, 32'h0);
        wr(`REG_ACC, 32'h0);
        wr(`REG_BREG, 32'h0);
        wr(`REG_DPTR, 32'h0);
        op(OP_INT_RETURN);
        chkrd(`REG_ACC, 32'hf, 32'h6);
        chkrd(`REG_BREG, 32'hf, 32'h9);
        chkrd(`REG_DPTR, 32'h3ff, 32'h2a5);
        chkrd(`REG_STATUS, 32'h1f, 32'h1f);
        op(OP_NOP);
        op(clear_carry_op);
        op(OP_CALL, 4'h0, 12'h100);
        op(OP_RETURN);
        op(OP_INT_RETURN);
        chkrd(`REG_STATUS, 32'h8, 32'h8);
        // the restored skip flag would swallow the next real op
        op(OP_NOP);
        $display("test interrupt done");
        // fixed waits only give the checker time to see each mode
        for (i = 0; i < 3; i++) begin
            wr(`REG_CTRL, i << 2);
            repeat (100) @(posedge clk);
        end
        op(OP_BACKUP_RETURN);
        chkrd(`REG_CTRL, 32'hc, 32'hc);
        repeat (100) @(posedge clk);
        $display("test clock done");
        apb(1'b0, 12'h040, 32'h0);
        chk({31'h0, e}, 32'h1);
        wr(12'h030, 32'h1);
        chk({31'h0, e}, 32'h1);
        $display("test unmapped done");
        results();
    end
endmodule : tb
